//--- logic/vconv_consts.svh
/*
 * register indices, field positions, mode codes, reset values and timing counts
 * of the virtual converter mapping, overrange and threshold detect block.
 * assumes: registers sit at byte address = 4 * index on a 32-bit apb bus.
 */
`ifndef VCONV_CONSTS_SVH
`define VCONV_CONSTS_SVH

// register indices (byte address is four times the index)
`define IDX_APP_MODE     12'h200
`define IDX_DEC_RATIO    12'h201
`define IDX_UPPER_LO     12'h247
`define IDX_UPPER_HI     12'h248
`define IDX_LOWER_LO     12'h249
`define IDX_LOWER_HI     12'h24a
`define IDX_DWELL_LO     12'h24b
`define IDX_DWELL_HI     12'h24c
`define IDX_DETECT_CTRL  12'h559
`define IDX_OVR_CLEAR    12'h562
`define IDX_OVR_STATUS   12'h563
`define IDX_IRQ_STATUS   12'h600
`define IDX_IRQ_CLEAR    12'h601
`define IDX_IRQ_ENABLE   12'h602

// field positions
`define MODE_MSB         3
`define QIGN_BIT         5
`define DEC_MSB          2
`define FD_EN_BIT        0
`define THR_W            13
`define THR_HI_MSB       4
`define IRQ_FD_A         0
`define IRQ_FD_B         1
`define IRQ_OVR          2
`define IRQ_W            3

// chip operating mode codes
`define MODE_ONE_DDC     4'h1
`define MODE_TWO_DDC     4'h2
`define MODE_FOUR_DDC    4'h3
`define MODE_REQUANT     4'h7
`define MODE_VAR_RANGE   4'h8

// reset values and limits
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define DWELL_MIN        16'h0001
`define DEC_MAX_CODE     3'h4
`define APB_ADDR_W       14

// threshold flag latency from input sample to pin, and the two front stages
`define DETECT_LATENCY   28
`define DETECT_FRONT     2

`endif

//--- logic/vconv_pkg.sv
/*
 * types shared by the virtual converter block.
 * assumes: nothing beyond the constants header.
 */
package vconv_pkg;
    // hysteresis state of one threshold detector
    typedef enum logic [1:0] {
        FD_QUIET  = 2'b01,
        FD_RAISED = 2'b10
    } fd_state_t;
endpackage

//--- logic/vconv_map_overrange_fast_detect.sv
/*
 * virtual converter mapping, sticky overrange status and two-channel
 * threshold detect with dwell hysteresis, behind an apb register slave.
 * assumes: adc, downconverter and overrange inputs come from logic on pclk,
 * already aligned sample for sample; a downstream receiver takes the outputs.
 */
// The APB register port is this design's own decision.
// How it works
// - mode from bits 3:0, q-ignore bit 5
// - decimation field sets output sample rate
// - each stream is one of eight converters
// - downconverter gives i/q pair or i only
// - modes 1,2,3 use one, two, four downconverters
// - complex: i on 2n, q on 2n+1
// - requantizer/range modes with q-ignore clear: a on 0, b on 1
// - overrange pins with sample data latency
// - sticky overrange bit per virtual converter
// - detect runs only when control enables it
// - flag set when magnitude exceeds upper threshold
// - flag clears after dwell below lower threshold
// - flag pin follows sample by 28 cycles
// - 13-bit lower threshold, full resolution compare
// - dwell 1 to 65535 cycles, two registers
// - independent detector and pin per channel
`include "vconv_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module vconv_map_overrange_fast_detect
    import vconv_pkg::*;
#(
    parameter int AW = 14, // adc sample width
    parameter int SW = 16  // virtual converter sample width
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // adc sample streams and overrange
    input  wire logic [AW-1:0]         adc_a_data,
    input  wire logic [AW-1:0]         adc_b_data,
    input  wire logic                  adc_a_ovr,
    input  wire logic                  adc_b_ovr,
    // downconverter channel outputs, channel n in slice n
    input  wire logic [4*SW-1:0]       ddc_i_data,
    input  wire logic [4*SW-1:0]       ddc_q_data,
    input  wire logic [3:0]            ddc_ovr,
    // virtual converter outputs
    output logic [8*SW-1:0]            vconv_data,
    output logic [7:0]                 vconv_valid,
    output logic [1:0]                 clip_status_pins,
    output logic                       threshold_flag_pin_a,
    output logic                       threshold_flag_pin_b,
    output logic                       irq
);
    localparam int FD_DLY = `DETECT_LATENCY - `DETECT_FRONT;

    // refuse widths the logic cannot serve
    initial begin
        if (AW < `THR_W + 1 || SW <= AW) begin
            $error("vconv: need AW > 13 and SW > AW");
        end
    end

    // true when virtual converter k carries a stream in the given mode
    function automatic logic vc_active(input logic [3:0] mode, input logic qign,
                                       input logic [2:0] k);
        logic [3:0] lim;
        lim = 4'h0;
        case (mode)
            `MODE_ONE_DDC:  lim = 4'h1;
            `MODE_TWO_DDC:  lim = 4'h2;
            `MODE_FOUR_DDC: lim = 4'h4;
            `MODE_REQUANT,
            `MODE_VAR_RANGE: lim = qign ? 4'h0 : 4'h1;
            default:        lim = 4'h0;
        endcase
        if (!qign) begin
            lim = 4'(lim << 1);
        end
        return {1'b0, k} < lim;
    endfunction

    // register match on an aligned word
    function automatic logic hit(input logic [`APB_ADDR_W-1:0] a, input logic [11:0] idx);
        return (a[1:0] == 2'h0) && (a[`APB_ADDR_W-1:2] == idx);
    endfunction

    // register storage
    logic [7:0]          app_mode_ff, dec_ratio_ff, detect_ctrl_ff, ovr_clear_ff, ovr_sts_ff;
    logic [15:0]         upper_ff, lower_ff, dwell_ff;
    logic [`IRQ_W-1:0]   irq_sts_ff, irq_en_ff;
    logic [31:0]         prdata_ff;
    logic                pready_ff, pslverr_ff, irq_ff;

    logic                setup, wr_en;
    logic [31:0]         nxt_rdata;
    logic                nxt_err;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_ff && pwrite;

    // read mux and unmapped detect, evaluated in the setup cycle
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        if      (hit(paddr, `IDX_APP_MODE))    nxt_rdata[7:0] = app_mode_ff;
        else if (hit(paddr, `IDX_DEC_RATIO))   nxt_rdata[7:0] = dec_ratio_ff;
        else if (hit(paddr, `IDX_UPPER_LO))    nxt_rdata[7:0] = upper_ff[7:0];
        else if (hit(paddr, `IDX_UPPER_HI))    nxt_rdata[7:0] = upper_ff[15:8];
        else if (hit(paddr, `IDX_LOWER_LO))    nxt_rdata[7:0] = lower_ff[7:0];
        else if (hit(paddr, `IDX_LOWER_HI))    nxt_rdata[7:0] = lower_ff[15:8];
        else if (hit(paddr, `IDX_DWELL_LO))    nxt_rdata[7:0] = dwell_ff[7:0];
        else if (hit(paddr, `IDX_DWELL_HI))    nxt_rdata[7:0] = dwell_ff[15:8];
        else if (hit(paddr, `IDX_DETECT_CTRL)) nxt_rdata[7:0] = detect_ctrl_ff;
        else if (hit(paddr, `IDX_OVR_CLEAR))   nxt_rdata[7:0] = ovr_clear_ff;
        else if (hit(paddr, `IDX_OVR_STATUS))  nxt_rdata[7:0] = ovr_sts_ff;
        else if (hit(paddr, `IDX_IRQ_STATUS))  nxt_rdata[`IRQ_W-1:0] = irq_sts_ff;
        else if (hit(paddr, `IDX_IRQ_CLEAR))   nxt_rdata = 32'h0000_0000;
        else if (hit(paddr, `IDX_IRQ_ENABLE))  nxt_rdata[`IRQ_W-1:0] = irq_en_ff;
        else                                   nxt_err = 1'b1;
    end

    // apb answer: ready in the first access cycle, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            prdata_ff  <= setup ? nxt_rdata : 32'h0000_0000;
            pslverr_ff <= setup && nxt_err;
        end
    end

    // software configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_mode_ff    <= `RST_BYTE;
            dec_ratio_ff   <= `RST_BYTE;
            upper_ff       <= `RST_WORD;
            lower_ff       <= `RST_WORD;
            dwell_ff       <= `DWELL_MIN;
            detect_ctrl_ff <= `RST_BYTE;
            ovr_clear_ff   <= `RST_BYTE;
            irq_en_ff      <= '0;
        end else if (wr_en) begin
            if (hit(paddr, `IDX_APP_MODE))    app_mode_ff     <= pwdata[7:0];
            if (hit(paddr, `IDX_DEC_RATIO))   dec_ratio_ff    <= pwdata[7:0];
            if (hit(paddr, `IDX_UPPER_LO))    upper_ff[7:0]   <= pwdata[7:0];
            if (hit(paddr, `IDX_UPPER_HI))    upper_ff[15:8]  <= pwdata[7:0];
            if (hit(paddr, `IDX_LOWER_LO))    lower_ff[7:0]   <= pwdata[7:0];
            if (hit(paddr, `IDX_LOWER_HI))    lower_ff[15:8]  <= pwdata[7:0];
            if (hit(paddr, `IDX_DWELL_LO))    dwell_ff[7:0]   <= pwdata[7:0];
            if (hit(paddr, `IDX_DWELL_HI))    dwell_ff[15:8]  <= pwdata[7:0];
            if (hit(paddr, `IDX_DETECT_CTRL)) detect_ctrl_ff  <= pwdata[7:0];
            if (hit(paddr, `IDX_OVR_CLEAR))   ovr_clear_ff    <= pwdata[7:0];
            if (hit(paddr, `IDX_IRQ_ENABLE))  irq_en_ff       <= pwdata[`IRQ_W-1:0];
        end
    end

    // decoded controls
    logic [3:0]          mode;
    logic                qign, fd_en;
    logic [3:0]          dec_lim;
    logic [`THR_W-1:0]   upper_thr, lower_thr;
    logic [15:0]         dwell_eff;
    assign mode      = app_mode_ff[`MODE_MSB:0];
    assign qign      = app_mode_ff[`QIGN_BIT];
    assign dec_lim   = (dec_ratio_ff[`DEC_MSB:0] <= `DEC_MAX_CODE) ?
                       4'((5'h01 << dec_ratio_ff[`DEC_MSB:0]) - 5'h01) : 4'h0;
    assign fd_en     = detect_ctrl_ff[`FD_EN_BIT];
    assign upper_thr = {upper_ff[8+`THR_HI_MSB:8], upper_ff[7:0]};
    assign lower_thr = {lower_ff[8+`THR_HI_MSB:8], lower_ff[7:0]};
    assign dwell_eff = (dwell_ff == `RST_WORD) ? `DWELL_MIN : dwell_ff;

    // decimation strobe: one output sample every ratio input samples
    logic [3:0] dec_cnt_ff;
    logic       strobe;
    assign strobe = (dec_cnt_ff == 4'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_cnt_ff <= 4'h0;
        end else begin
            dec_cnt_ff <= (dec_cnt_ff >= dec_lim) ? 4'h0 : 4'(dec_cnt_ff + 4'h1);
        end
    end

    // virtual converter mapping, one slice per converter
    logic [8*SW-1:0] vconv_data_ff;
    logic [7:0]      vconv_valid_ff, vc_ovr;
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_vc
            localparam int NI = k % 4;       // downconverter when q is ignored
            localparam int NC = k / 2;       // downconverter when complex
            logic [SW-1:0] sel;
            logic          act, src_ovr;
            assign act = vc_active(mode, qign, 3'(k));
            always_comb begin
                sel     = '0;
                src_ovr = 1'b0;
                if (mode == `MODE_REQUANT || mode == `MODE_VAR_RANGE) begin
                    if (k == 0) begin
                        sel     = {{(SW-AW){adc_a_data[AW-1]}}, adc_a_data};
                        src_ovr = adc_a_ovr;
                    end else begin
                        sel     = {{(SW-AW){adc_b_data[AW-1]}}, adc_b_data};
                        src_ovr = adc_b_ovr;
                    end
                end else if (qign) begin
                    sel     = ddc_i_data[NI*SW +: SW];
                    src_ovr = ddc_ovr[NI];
                end else begin
                    sel     = (k % 2 == 1) ? ddc_q_data[NC*SW +: SW] : ddc_i_data[NC*SW +: SW];
                    src_ovr = ddc_ovr[NC];
                end
            end
            assign vc_ovr[k] = act && strobe && src_ovr;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vconv_data_ff[k*SW +: SW] <= '0;
                    vconv_valid_ff[k]         <= 1'b0;
                end else begin
                    vconv_data_ff[k*SW +: SW] <= (act && strobe) ? sel : '0;
                    vconv_valid_ff[k]         <= act && strobe;
                end
            end
        end
    endgenerate

    // overrange pins, one stage like the sample path
    logic [1:0] clip_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clip_ff <= 2'h0;
        end else begin
            clip_ff <= {adc_b_ovr, adc_a_ovr};
        end
    end

    // sticky overrange status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_sts_ff <= `RST_BYTE;
        end else begin
            ovr_sts_ff <= (ovr_sts_ff & ~ovr_clear_ff) | vc_ovr;
        end
    end

    // per channel threshold detectors
    logic [1:0] fd_pin, fd_rise;
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_fd
            logic [AW-1:0]    raw, mag, mag_ff;
            logic [15:0]      dwl_ff;
            logic [FD_DLY-1:0] dly_ff;
            fd_state_t        st_ff;
            logic             above, below;
            assign raw   = (c == 0) ? adc_a_data : adc_b_data;
            assign mag   = raw[AW-1] ? AW'(~raw + 1'b1) : raw;
            assign above = mag_ff > AW'(upper_thr);
            assign below = mag_ff < AW'(lower_thr);
            // magnitude stage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mag_ff <= '0;
                end else begin
                    mag_ff <= mag;
                end
            end
            // hysteresis state and dwell count
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_ff  <= FD_QUIET;
                    dwl_ff <= `RST_WORD;
                end else begin
                    case (st_ff)
                        FD_QUIET: begin
                            dwl_ff <= `RST_WORD;
                            if (fd_en && above) begin
                                st_ff <= FD_RAISED;
                            end
                        end
                        FD_RAISED: begin
                            if (!fd_en) begin
                                st_ff  <= FD_QUIET;
                                dwl_ff <= `RST_WORD;
                            end else if (!below) begin
                                dwl_ff <= `RST_WORD;
                            end else if (dwl_ff >= dwell_eff) begin
                                st_ff  <= FD_QUIET;
                                dwl_ff <= `RST_WORD;
                            end else begin
                                dwl_ff <= 16'(dwl_ff + 16'h0001);
                            end
                        end
                        default: begin
                            st_ff  <= FD_QUIET;
                            dwl_ff <= `RST_WORD;
                        end
                    endcase
                end
            end
            // delay line to the pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dly_ff <= '0;
                end else begin
                    dly_ff <= {dly_ff[FD_DLY-2:0], st_ff == FD_RAISED};
                end
            end
            assign fd_pin[c]  = dly_ff[FD_DLY-1];
            assign fd_rise[c] = dly_ff[FD_DLY-2] && !dly_ff[FD_DLY-1];

            sequence s_cross;
                fd_en && (raw[AW-1] ? AW'(~raw + 1'b1) : raw) > AW'(upper_thr) ##1 fd_en;
            endsequence
            a_flag_latency: assert property (@(posedge pclk) disable iff (!presetn)
                s_cross |-> ##27 fd_pin[c])
                else $error("flag pin not high 28 cycles after crossing");
            a_dwell_hold: assert property (@(posedge pclk) disable iff (!presetn)
                (st_ff == FD_RAISED) && fd_en && !below |=> st_ff == FD_RAISED)
                else $error("flag dropped at or above lower threshold");
            a_dwell_clear: assert property (@(posedge pclk) disable iff (!presetn)
                (st_ff == FD_RAISED) && $fell(st_ff == FD_RAISED) == 1'b0 && fd_en &&
                below && dwl_ff < dwell_eff |=> st_ff == FD_RAISED)
                else $error("flag cleared before dwell time");
            a_fd_disabled: assert property (@(posedge pclk) disable iff (!presetn)
                !fd_en [*2] |-> st_ff == FD_QUIET)
                else $error("detector active while disabled");
        end
    endgenerate

    // interrupt status, clear by writing ones; set wins over clear
    logic [`IRQ_W-1:0] irq_ev, irq_clr;
    assign irq_ev  = {(|vc_ovr), fd_rise[1], fd_rise[0]};
    assign irq_clr = (wr_en && hit(paddr, `IDX_IRQ_CLEAR)) ? pwdata[`IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_ff <= '0;
            irq_ff     <= 1'b0;
        end else begin
            irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_ev;
            irq_ff     <= |(irq_sts_ff & irq_en_ff);
        end
    end

    // output ports
    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign vconv_data           = vconv_data_ff;
    assign vconv_valid          = vconv_valid_ff;
    assign clip_status_pins     = clip_ff;
    assign threshold_flag_pin_a = fd_pin[0];
    assign threshold_flag_pin_b = fd_pin[1];
    assign irq                  = irq_ff;

    sequence s_setup;
        psel && !penable;
    endsequence
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready && psel && penable)
        else $error("no ready in first access cycle");
    a_ovr_set: assert property (@(posedge pclk) disable iff (!presetn)
        vc_ovr != 8'h00 |=> (ovr_sts_ff & $past(vc_ovr)) == $past(vc_ovr))
        else $error("overrange event not recorded");
    a_ovr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ovr_clear_ff == 8'h00 |=> (ovr_sts_ff & $past(ovr_sts_ff)) == $past(ovr_sts_ff))
        else $error("sticky overrange bit lost");
    a_vc_unused: assert property (@(posedge pclk) disable iff (!presetn)
        !vc_active(mode, qign, 3'h7) && !vc_active(mode, qign, 3'h2) |=>
        !vconv_valid[7] && !vconv_valid[2])
        else $error("inactive virtual converter marked valid");
    a_clip_latency: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 clip_status_pins == $past({adc_b_ovr, adc_a_ovr}))
        else $error("clip pins latency wrong");
    a_dec_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        strobe && dec_lim == 4'h1 && $stable(dec_lim) ##1 $stable(dec_lim) |-> !strobe ##1 strobe)
        else $error("decimate by two strobe spacing wrong");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |($past(irq_sts_ff) & $past(irq_en_ff)))
        else $error("interrupt level mismatch");
endmodule

`default_nettype wire

//--- test/vconv_rx_model.sv
/* downstream receiver stand-in: counts samples taken on converter 0.
   assumes it shares pclk and presetn with the block. */
`timescale 1ns/1ns
`default_nettype none
module vconv_rx_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // sample strobes
    input  wire logic [7:0] vconv_valid,
    output int              samples_seen
);
    // take every strobed sample of converter 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samples_seen <= 0;
        end else if (vconv_valid[0] === 1'b1) begin
            samples_seen <= samples_seen + 1;
        end
    end
endmodule
`default_nettype wire

//--- test/vconv_map_overrange_fast_detect_tb.sv
/* bench: apb registers, converter mapping, decimation, overrange, detect, irq.
   assumes the constants header and the receiver model. */
`include "vconv_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module vconv_map_overrange_fast_detect_tb;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic         ova, ovb, fa, fb, irq;
    logic [13:0]  paddr, adc_a, adc_b;
    logic [31:0]  pwdata, prdata, rd;
    logic [63:0]  di, dq;
    logic [3:0]   dov;
    logic [127:0] vd;
    logic [7:0]   vv;
    logic [1:0]   clip;
    int           err_count, cmp_count, seen, s0;

    vconv_map_overrange_fast_detect dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_a_data(adc_a), .adc_b_data(adc_b),
        .adc_a_ovr(ova), .adc_b_ovr(ovb), .ddc_i_data(di), .ddc_q_data(dq), .ddc_ovr(dov),
        .vconv_data(vd), .vconv_valid(vv), .clip_status_pins(clip),
        .threshold_flag_pin_a(fa), .threshold_flag_pin_b(fb), .irq(irq));
    vconv_rx_model rx_u (.pclk(pclk), .presetn(presetn), .vconv_valid(vv), .samples_seen(seen));

    // clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h", $time, what, got);
        end
    endtask

    // one apb transfer, started after an edge, held until pready
    task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task edges(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task test_regs;
        apb(1'b0, `IDX_DWELL_LO, 32'h0);
        chk(rd, 32'h1, "dwell reset");
        apb(1'b1, `IDX_APP_MODE, 32'h25);
        apb(1'b0, `IDX_APP_MODE, 32'h0);
        chk(rd, 32'h25, "mode rw");
        apb(1'b0, 12'h100, 32'h0);
        chk(er, 1'b1, "unmapped");
        apb(1'b1, `IDX_OVR_STATUS, 32'hff);
        apb(1'b0, `IDX_OVR_STATUS, 32'h0);
        chk(rd, 32'h0, "status ro");
        $display("test regs done");
    endtask

    task test_map;
        di <= 64'h4444_3333_2222_1111;
        dq <= 64'h8888_7777_6666_5555;
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, `IDX_APP_MODE, 32'h20 | m);
            edges(2);
            chk(vv, (9'h1 << (1 << (m - 1))) - 9'h1, "real count");
            if (m == 3) chk(vd, {64'h0, di}, "real order");
            apb(1'b1, `IDX_APP_MODE, m);
            edges(2);
            chk(vv, (9'h1 << (2 << (m - 1))) - 9'h1, "complex count");
        end
        chk(vd, 128'h8888_4444_7777_3333_6666_2222_5555_1111, "complex order");
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, `IDX_DEC_RATIO, c);
            edges(8);
            s0 = seen;
            edges(32);
            chk(seen - s0, 32 >> c, "rate");
        end
        // back to full rate so the later single-cycle checks see a strobe
        apb(1'b1, `IDX_DEC_RATIO, 32'h0);
        adc_a <= 14'h2001;
        adc_b <= 14'h0123;
        for (int m = 7; m < 9; m++) begin
            apb(1'b1, `IDX_APP_MODE, m);
            edges(2);
            chk(vv, 8'h03, "adc map valid");
            chk(vd, {96'h0, 16'h0123, 16'he001}, "adc map data");
        end
        $display("test map done");
    endtask

    task test_ovr;
        ova <= 1'b1;
        edges(1);
        ova <= 1'b0;
        edges(1);
        chk(clip, 2'b01, "clip pin");
        apb(1'b0, `IDX_OVR_STATUS, 32'h0);
        chk(rd, 32'h1, "sticky");
        apb(1'b1, `IDX_OVR_CLEAR, 32'h1);
        apb(1'b1, `IDX_OVR_CLEAR, 32'h0);
        apb(1'b0, `IDX_OVR_STATUS, 32'h0);
        chk(rd, 32'h0, "cleared");
        $display("test overrange done");
    endtask

    task test_detect;
        // channel a quiet, so its detector must stay low while b fires
        adc_a <= 14'h0;
        apb(1'b1, `IDX_UPPER_LO, 32'h64);
        apb(1'b1, `IDX_LOWER_LO, 32'h32);
        apb(1'b1, `IDX_IRQ_ENABLE, 32'h2);
        for (int en = 0; en < 2; en++) begin
            apb(1'b1, `IDX_DETECT_CTRL, en);
            edges(2);
            // two large samples: the second one sits above lower while raised
            adc_b <= 14'h3f38;
            edges(2);
            adc_b <= 14'h0;
            edges(26);
            chk(fb, 1'b0, "early");
            edges(1);
            chk({fa, fb}, {1'b0, en[0]}, "flag");
        end
        edges(40);
        chk({fb, irq}, 2'b01, "fall");
        apb(1'b1, `IDX_IRQ_ENABLE, 32'h0);
        edges(2);
        chk(irq, 1'b0, "masked");
        apb(1'b1, `IDX_IRQ_CLEAR, 32'h2);
        apb(1'b1, `IDX_IRQ_ENABLE, 32'h2);
        edges(2);
        chk(irq, 1'b0, "irq clear");
        $display("test detect done");
    endtask

    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog
    initial begin
        #100000;
        err_count++;
        report_and_stop;
    end

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ova, ovb, dov} = '0;
        {adc_a, adc_b, di, dq} = '0;
        edges(5);
        presetn <= 1'b1;
        test_regs;
        test_map;
        test_ovr;
        test_detect;
        report_and_stop;
    end
endmodule
`default_nettype wire
